// [acsr_host.sv]
// host model driving frames onto the serial link
`timescale 1ns/1ps
`default_nettype none
module acsr_host (
	// clock for edge alignment
	input wire logic i_clock,
	// serial link pins
	output logic o_sclk,
	output logic o_ss_n,
	output logic o_mosi
);
	initial begin
		o_sclk = 0;
		o_ss_n = 1;
		o_mosi = 0;
	end
	// control byte with load flags leads the data word
	task automatic send(input logic [23:0] f);
		@(negedge i_clock);
		o_ss_n = 0;
		#100;
		for (int i = 23; i >= 0; i--) begin
			o_mosi = f[i];
			#80 o_sclk = 1;
			#80 o_sclk = 0;
		end
		// released line must not keep showing its last bit
		o_mosi = ~o_mosi;
		#80 o_ss_n = 1;
		#400;
	endtask
endmodule
`default_nettype wire

// [acsr_monitor.sv]
// checker for the live settings of the shadow register bank
`timescale 1ns/1ps
`default_nettype none
module acsr_monitor (
	// clock, reset, select
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_ss_n,
	// live settings
	input wire logic o_power_up_bit,
	input wire logic [15:0] o_audio_config_word_a,
	input wire logic [15:0] o_audio_config_word_b,
	input wire logic o_gain_ctrl_amp_powerdown,
	input wire logic o_filter_powerdown,
	input wire logic [1:0] o_rate_sel,
	input wire logic o_filter_src_array,
	input wire logic [1:0] o_mixer_b_ctrl,
	input wire logic [1:0] o_mixer_a_ctrl,
	input wire logic [1:0] o_mixer_a_source,
	input wire logic o_mixer_a_source_unused,
	input wire logic [2:0] o_attenuation,
	input wire logic [1:0] o_level_ctrl_source
);
	wire [15:0] b;
	wire p;
	assign b = o_audio_config_word_b;
	assign p = o_power_up_bit;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	agc_pd_map_a: assert property (
		o_gain_ctrl_amp_powerdown == (b[0] | !p)) else $error("gain pd");
	flt_pd_map_a: assert property (
		o_filter_powerdown == (b[1] | !p)) else $error("filter pd");
	rate_map_a: assert property (
		o_rate_sel == b[3:2]) else $error("rate");
	flt_src_map_a: assert property (
		o_filter_src_array == b[4]) else $error("filter src");
	mixb_map_a: assert property (
		o_mixer_b_ctrl == (p ? b[6:5] : 2'h3)) else $error("mixer b");
	mixa_map_a: assert property (
		o_mixer_a_ctrl == (p ? b[8:7] : 2'h3)) else $error("mixer a");
	srca_map_a: assert property (o_mixer_a_source == b[10:9] &&
		o_mixer_a_source_unused == (b[10:9] == 2'h3)) else $error("src a");
	atten_map_a: assert property (
		o_attenuation == b[13:11]) else $error("attenuation");
	lvl_map_a: assert property (
		o_level_ctrl_source == b[15:14]) else $error("level src");
	word_hold_a: assert property ((!i_ss_n)[*8] |=>
		$stable(o_audio_config_word_a) && $stable(b)) else $error("held");
	cover property ($rose(p));
	cover property ($changed(o_audio_config_word_a));
	cover property (o_mixer_a_source_unused);
endmodule
`default_nettype wire

// [acsr_pkg.sv]
// package for the audio configuration shadow register bank
package acsr_pkg;
	localparam int WORD_W = 16;
	localparam int SYNC_W = 3;
	// serial control word layout, as clocked in msb first
	localparam int CTRL_W = 8;
	localparam int CTRL_PWR_BIT = 7;
	localparam int CTRL_LDA_BIT = 1;
	localparam int CTRL_LDB_BIT = 0;
	localparam int FRAME_W = 24;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	// second word field positions
	localparam int B_AGC_PD = 0;
	localparam int B_FLT_PD = 1;
	localparam int B_RATE_LO = 2;
	localparam int B_FLT_SRC = 4;
	localparam int B_MIXB_LO = 5;
	localparam int B_MIXA_LO = 7;
	localparam int B_MIXA_SRC_LO = 9;
	localparam int B_ATTEN_LO = 11;
	localparam int B_LVL_SRC_LO = 14;
	localparam logic [1:0] MIX_PWRDN = 2'h3;
	localparam logic [1:0] SRC_UNUSED = 2'h3;
	localparam logic [15:0] WORD_RST = 16'h0000;
	typedef enum logic [1:0] {
		ACSR_IDLE = 2'b00,
		ACSR_SHIFT = 2'b01,
		ACSR_DONE = 2'b10
	} acsr_state_t;
endpackage

// [acsr_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module acsr_sync #(
	// level held through reset, matching the pin's idle level
	parameter logic RST_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// pin in, filtered level out
	input wire logic i_pin,
	output logic o_level
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic level_q;
	logic level_d;
	always_comb begin
		stage_d = {stage_q[1:0], i_pin};
		// stage 0 feeds only stage 1
		level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
	end
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			// a wrong reset level would show a false edge after reset
			stage_q <= {3{RST_LEVEL}};
			level_q <= RST_LEVEL;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end
	assign o_level = level_q;
endmodule
`default_nettype wire

// [acsr_top.sv]
// shadowed audio configuration words loaded over a serial link
`timescale 1ns/1ps
`default_nettype none
module acsr_top (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// serial link pins
	input wire logic i_sclk,
	input wire logic i_ss_n,
	input wire logic i_mosi,
	// live settings
	output logic o_power_up_bit,
	output logic [15:0] o_audio_config_word_a,
	output logic [15:0] o_audio_config_word_b,
	output logic o_gain_ctrl_amp_powerdown,
	output logic o_filter_powerdown,
	output logic [1:0] o_rate_sel,
	output logic o_filter_src_array,
	output logic [1:0] o_mixer_b_ctrl,
	output logic [1:0] o_mixer_a_ctrl,
	output logic [1:0] o_mixer_a_source,
	output logic o_mixer_a_source_unused,
	output logic [2:0] o_attenuation,
	output logic [1:0] o_level_ctrl_source
);
	logic sclk_s;
	logic ss_n_s;
	logic mosi_s;
	acsr_sync u_sync_sclk (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_pin(i_sclk),
		.o_level(sclk_s)
	);
	// select idles high: reset there so no phantom frame opens
	acsr_sync #(
		.RST_LEVEL(1'b1)
	) u_sync_ss (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_pin(i_ss_n),
		.o_level(ss_n_s)
	);
	acsr_sync u_sync_mosi (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_pin(i_mosi),
		.o_level(mosi_s)
	);

	// frame capture
	acsr_pkg::acsr_state_t state_q, state_d;
	logic sclk_prev_q, sclk_prev_d;
	logic [23:0] shift_q, shift_d;
	logic [4:0] count_q, count_d;
	logic sclk_rise;
	// mosi passes the same delay as sclk, so sampling stays aligned
	assign sclk_rise = sclk_s && !sclk_prev_q;

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		count_d = count_q;
		sclk_prev_d = sclk_s;
		case (state_q)
			acsr_pkg::ACSR_IDLE: begin
				count_d = 5'h00;
				if (!ss_n_s) begin
					state_d = acsr_pkg::ACSR_SHIFT;
				end
			end
			acsr_pkg::ACSR_SHIFT: begin
				if (ss_n_s) begin
					state_d = acsr_pkg::ACSR_DONE;
				end else if (sclk_rise && count_q != acsr_pkg::FRAME_BITS) begin
					shift_d = {shift_q[22:0], mosi_s};
					count_d = count_q + 5'h01;
				end
			end
			acsr_pkg::ACSR_DONE: begin
				state_d = acsr_pkg::ACSR_IDLE;
			end
			default: begin
				state_d = acsr_pkg::ACSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= acsr_pkg::ACSR_IDLE;
			sclk_prev_q <= 1'b0;
			shift_q <= 24'h000000;
			count_q <= 5'h00;
		end else begin
			state_q <= state_d;
			sclk_prev_q <= sclk_prev_d;
			shift_q <= shift_d;
			count_q <= count_d;
		end
	end

	// register bank
	logic [7:0] ctrl;
	logic [15:0] data;
	logic frame_ok;
	logic [15:0] hold_q, hold_d;
	logic [15:0] word_a_q, word_a_d;
	logic [15:0] word_b_q, word_b_d;
	logic pwr_q, pwr_d;
	assign ctrl = shift_q[23:16];
	assign data = shift_q[15:0];
	// short frames are dropped whole
	assign frame_ok = (state_q == acsr_pkg::ACSR_DONE)
		&& (count_q == acsr_pkg::FRAME_BITS);

	always_comb begin
		hold_d = hold_q;
		word_a_d = word_a_q;
		word_b_d = word_b_q;
		pwr_d = pwr_q;
		// accepted regardless of power state
		if (frame_ok) begin
			pwr_d = ctrl[acsr_pkg::CTRL_PWR_BIT];
			if (ctrl[acsr_pkg::CTRL_LDA_BIT]) begin
				hold_d = data;
			end
			if (ctrl[acsr_pkg::CTRL_LDB_BIT]) begin
				word_b_d = data;
				// same-frame a and b load: holding value predates this frame
				word_a_d = hold_q;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			hold_q <= acsr_pkg::WORD_RST;
			word_a_q <= acsr_pkg::WORD_RST;
			word_b_q <= acsr_pkg::WORD_RST;
			pwr_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
			word_a_q <= word_a_d;
			word_b_q <= word_b_d;
			pwr_q <= pwr_d;
		end
	end

	// decoded outputs; powerdown flags and mixer controls forced to powered-down state while not powered up
	logic [15:0] eff_b;
	logic pdn;
	logic gpd_q, fpd_q, fsrc_q, unused_q;
	logic [1:0] rate_q, mixb_q, mixa_q, asrc_q, lsrc_q;
	logic [2:0] att_q;
	logic gpd_d, fpd_d, fsrc_d, unused_d;
	logic [1:0] rate_d, mixb_d, mixa_d, asrc_d, lsrc_d;
	logic [2:0] att_d;
	assign eff_b = word_b_d;
	assign pdn = !pwr_d;

	always_comb begin
		gpd_d = eff_b[acsr_pkg::B_AGC_PD] | pdn;
		fpd_d = eff_b[acsr_pkg::B_FLT_PD] | pdn;
		rate_d = eff_b[acsr_pkg::B_RATE_LO +: 2];
		fsrc_d = eff_b[acsr_pkg::B_FLT_SRC];
		mixb_d = pdn ? acsr_pkg::MIX_PWRDN
			: eff_b[acsr_pkg::B_MIXB_LO +: 2];
		mixa_d = pdn ? acsr_pkg::MIX_PWRDN
			: eff_b[acsr_pkg::B_MIXA_LO +: 2];
		asrc_d = eff_b[acsr_pkg::B_MIXA_SRC_LO +: 2];
		unused_d = (asrc_d == acsr_pkg::SRC_UNUSED);
		att_d = eff_b[acsr_pkg::B_ATTEN_LO +: 3];
		lsrc_d = eff_b[acsr_pkg::B_LVL_SRC_LO +: 2];
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			gpd_q <= 1'b1;
			fpd_q <= 1'b1;
			rate_q <= 2'h0;
			fsrc_q <= 1'b0;
			mixb_q <= acsr_pkg::MIX_PWRDN;
			mixa_q <= acsr_pkg::MIX_PWRDN;
			asrc_q <= 2'h0;
			unused_q <= 1'b0;
			att_q <= 3'h0;
			lsrc_q <= 2'h0;
		end else begin
			gpd_q <= gpd_d;
			fpd_q <= fpd_d;
			rate_q <= rate_d;
			fsrc_q <= fsrc_d;
			mixb_q <= mixb_d;
			mixa_q <= mixa_d;
			asrc_q <= asrc_d;
			unused_q <= unused_d;
			att_q <= att_d;
			lsrc_q <= lsrc_d;
		end
	end

	assign o_power_up_bit = pwr_q;
	assign o_audio_config_word_a = word_a_q;
	assign o_audio_config_word_b = word_b_q;
	assign o_gain_ctrl_amp_powerdown = gpd_q;
	assign o_filter_powerdown = fpd_q;
	assign o_rate_sel = rate_q;
	assign o_filter_src_array = fsrc_q;
	assign o_mixer_b_ctrl = mixb_q;
	assign o_mixer_a_ctrl = mixa_q;
	assign o_mixer_a_source = asrc_q;
	assign o_mixer_a_source_unused = unused_q;
	assign o_attenuation = att_q;
	assign o_level_ctrl_source = lsrc_q;
endmodule
`default_nettype wire

// [testbench.sv]
// testbench for the audio configuration shadow register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clock, i_rstn;
	wire logic i_sclk, i_ss_n, i_mosi;
	logic o_power_up_bit, o_gain_ctrl_amp_powerdown, o_filter_powerdown;
	logic o_filter_src_array, o_mixer_a_source_unused;
	logic [15:0] o_audio_config_word_a, o_audio_config_word_b, d, hold;
	logic [1:0] o_rate_sel, o_mixer_b_ctrl, o_mixer_a_ctrl;
	logic [1:0] o_mixer_a_source, o_level_ctrl_source;
	logic [2:0] o_attenuation;
	int mismatches, total_checks, cyc;
	acsr_top dut_u (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_sclk(i_sclk),
		.i_ss_n(i_ss_n),
		.i_mosi(i_mosi),
		.o_power_up_bit(o_power_up_bit),
		.o_audio_config_word_a(o_audio_config_word_a),
		.o_audio_config_word_b(o_audio_config_word_b),
		.o_gain_ctrl_amp_powerdown(o_gain_ctrl_amp_powerdown),
		.o_filter_powerdown(o_filter_powerdown),
		.o_rate_sel(o_rate_sel),
		.o_filter_src_array(o_filter_src_array),
		.o_mixer_b_ctrl(o_mixer_b_ctrl),
		.o_mixer_a_ctrl(o_mixer_a_ctrl),
		.o_mixer_a_source(o_mixer_a_source),
		.o_mixer_a_source_unused(o_mixer_a_source_unused),
		.o_attenuation(o_attenuation),
		.o_level_ctrl_source(o_level_ctrl_source)
	);
	acsr_host host_u (.i_clock(i_clock), .o_sclk(i_sclk), .o_ss_n(i_ss_n),
		.o_mosi(i_mosi));
	always #10 i_clock = ~i_clock;
	task chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: %h not %h", $time, s, e);
		end
	endtask
	task print_verdict;
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task fields(input logic [15:0] w, input logic p);
		chk(o_audio_config_word_b, w);
		chk(o_power_up_bit, p);
		chk(o_gain_ctrl_amp_powerdown, w[0] | !p);
		chk(o_filter_powerdown, w[1] | !p);
		chk(o_rate_sel, w[3:2]);
		chk(o_filter_src_array, w[4]);
		chk(o_mixer_b_ctrl, p ? w[6:5] : 2'h3);
		chk(o_mixer_a_ctrl, p ? w[8:7] : 2'h3);
		chk(o_mixer_a_source, w[10:9]);
		chk(o_mixer_a_source_unused, &w[10:9]);
		chk(o_attenuation, w[13:11]);
		chk(o_level_ctrl_source, w[15:14]);
	endtask
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 10000) begin
			mismatches++;
			print_verdict;
		end
	end
	initial begin
		i_clock = 0;
		i_rstn = 0;
		repeat (5) @(posedge i_clock);
		@(negedge i_clock) i_rstn = 1;
		repeat (5) @(negedge i_clock);
		fields(16'h0000, 1'b0);
		host_u.send({8'h02, 16'h1234});
		chk(o_audio_config_word_a, 16'h0000);
		host_u.send({8'h02, 16'habcd});
		host_u.send({8'h01, 16'h0000});
		chk(o_audio_config_word_a, 16'habcd);
		fields(16'h0000, 1'b0);
		hold = 16'habcd;
		// every field code appears at least once over the eight frames
		for (int k = 0; k < 8; k++) begin
			d = {k[1:0], k[2:0], k[1:0], k[1:0], k[1:0], k[0], k[1:0], k[1:0]};
			host_u.send({8'h83, d});
			chk(o_audio_config_word_a, hold);
			fields(d, 1'b1);
			hold = d;
		end
		host_u.send({8'h00, 16'hffff});
		fields(d, 1'b0);
		print_verdict;
	end
endmodule
bind acsr_top acsr_monitor mon_u (
	.i_clock(i_clock),
	.i_rstn(i_rstn),
	.i_ss_n(i_ss_n),
	.o_power_up_bit(o_power_up_bit),
	.o_audio_config_word_a(o_audio_config_word_a),
	.o_audio_config_word_b(o_audio_config_word_b),
	.o_gain_ctrl_amp_powerdown(o_gain_ctrl_amp_powerdown),
	.o_filter_powerdown(o_filter_powerdown),
	.o_rate_sel(o_rate_sel),
	.o_filter_src_array(o_filter_src_array),
	.o_mixer_b_ctrl(o_mixer_b_ctrl),
	.o_mixer_a_ctrl(o_mixer_a_ctrl),
	.o_mixer_a_source(o_mixer_a_source),
	.o_mixer_a_source_unused(o_mixer_a_source_unused),
	.o_attenuation(o_attenuation),
	.o_level_ctrl_source(o_level_ctrl_source)
);
`default_nettype wire
